// File: src/acl_pkg.sv
// Notes on behaviour
// - mode field: standby, measure, level, pulse
// - range codes 00 8g, 10 4g, 01 2g
// - standby: no sampling, registers stay accessible
// - all axes sampled; 10-bit only at 8g
// - sample rate 125 Hz or 250 Hz
// - all axes done: ready bit set, ready pin too unless suppressed
// - ready held until an axis register read
// - overwrite of unread sample sets overrun
// - measure mode: no level or pulse detection
// - level mode measures; any axis combination enabled
// - polarity 0: any enabled axis >= threshold
// - polarity 1: all enabled axes <= threshold
// - one threshold, signed or absolute compare
// - control bit routes event to pin a or b
// - detection source register mirrors detection status
// - event latched until host sets clear bit
// - self-test shifts z output by 1g
// - pulse duration 0.5 to 127 ms, 0.5 steps
// - latency 1-150 ms, window 0-250 ms
// - threshold has 128 levels, zero to full scale, in absolute compare; signed compare uses all 8 bits
// - detection path runs at 600 Hz
// - bandwidth bit: 0 62.5 Hz, 1 125 Hz
package acl_pkg;

  // clock and rates
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned RATE_LO_HZ  = 125;
  localparam int unsigned RATE_HI_HZ  = 250;
  localparam int unsigned DET_HZ      = 600;
  localparam int unsigned RATE_LO_CYC = CLK_HZ / RATE_LO_HZ;
  localparam int unsigned RATE_HI_CYC = CLK_HZ / RATE_HI_HZ;
  localparam int unsigned DET_CYC     = CLK_HZ / DET_HZ;
  localparam int unsigned TMR_W       = 17;

  // detection timer limits
  localparam int unsigned PDUR_STEP_US = 500;
  localparam int unsigned PDUR_MAX_MS  = 127;
  localparam logic [7:0]  PDUR_MAX     =
    8'(PDUR_MAX_MS * 1000 / PDUR_STEP_US);
  localparam logic [7:0]  LAT_MAX_MS   = 8'h96;
  localparam logic [7:0]  TW_MAX_MS    = 8'hFA;
  localparam logic [7:0]  TMR_MIN      = 8'h01;

  // self-test deflection, 1g at 64 LSB/g on the 10-bit scale
  localparam logic [10:0] SELFTEST_LSB = 11'h040;

  // register offsets
  localparam logic [7:0] ADDR_XL     = 8'h00;
  localparam logic [7:0] ADDR_XH     = 8'h01;
  localparam logic [7:0] ADDR_YL     = 8'h02;
  localparam logic [7:0] ADDR_YH     = 8'h03;
  localparam logic [7:0] ADDR_ZL     = 8'h04;
  localparam logic [7:0] ADDR_ZH     = 8'h05;
  localparam logic [7:0] ADDR_X8     = 8'h06;
  localparam logic [7:0] ADDR_Y8     = 8'h07;
  localparam logic [7:0] ADDR_Z8     = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h09;
  localparam logic [7:0] ADDR_DETSRC = 8'h0A;
  localparam logic [7:0] ADDR_MODE   = 8'h16;
  localparam logic [7:0] ADDR_LATCLR = 8'h17;
  localparam logic [7:0] ADDR_CTL1   = 8'h18;
  localparam logic [7:0] ADDR_CTL2   = 8'h19;
  localparam logic [7:0] ADDR_THR    = 8'h1A;
  localparam logic [7:0] ADDR_PDUR   = 8'h1C;
  localparam logic [7:0] ADDR_LAT    = 8'h1D;
  localparam logic [7:0] ADDR_TW     = 8'h1E;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] THR_RST  = 8'h00;
  localparam logic [7:0] TMR_RST  = 8'h00;

  // control 1 field positions
  localparam int unsigned CTL1_PIN_SEL = 0;
  localparam int unsigned CTL1_XDIS    = 3;
  localparam int unsigned CTL1_ABS     = 6;
  localparam int unsigned CTL1_BW      = 7;
  // control 2 field position
  localparam int unsigned CTL2_POL     = 0;
  // status field positions
  localparam int unsigned ST_READY     = 0;
  localparam int unsigned ST_OVR       = 1;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_MEASURE = 2'b01,
    MODE_LEVEL   = 2'b10,
    MODE_PULSE   = 2'b11
  } acl_op_mode_t;

  typedef enum logic [1:0] {
    RANGE_8G = 2'b00,
    RANGE_2G = 2'b01,
    RANGE_4G = 2'b10,
    RANGE_XX = 2'b11
  } acl_range_t;

  typedef struct packed {
    logic         reserved;
    logic         ready_pin_suppress;
    logic         three_wire_serial_sel;
    logic         selftest_on;
    acl_range_t   range_select;
    acl_op_mode_t mode;
  } acl_mode_reg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acl_reg_req_t;

endpackage

// File: src/acl_level_cmp.sv
`timescale 1ns/1ps
module acl_level_cmp
  import acl_pkg::*;
(
  // axis sample and threshold
  input  wire logic [7:0] value_i,
  input  wire logic [7:0] thr_i,
  input  wire logic       abs_i,
  // compare results
  output logic            ge_o,
  output logic            le_o
);

  logic [7:0] mag;
  logic [7:0] thr_mag;

  always_comb begin
    mag     = value_i[7] ? 8'(-value_i) : value_i;
    thr_mag = {1'b0, thr_i[6:0]};
    if (abs_i) begin
      ge_o = mag >= thr_mag;
      le_o = mag <= thr_mag;
    end else begin
      ge_o = $signed(value_i) >= $signed(thr_i);
      le_o = $signed(value_i) <= $signed(thr_i);
    end
  end

endmodule

// File: src/acl_ctrl.sv
`timescale 1ns/1ps
module acl_ctrl
  import acl_pkg::*;
#(
  parameter int unsigned RATE_LO_CYCLES = RATE_LO_CYC,
  parameter int unsigned RATE_HI_CYCLES = RATE_HI_CYC,
  parameter int unsigned DET_CYCLES     = DET_CYC
)(
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          reset_i,
  // register access from the serial host port
  input  wire acl_reg_req_t  reg_req_i,
  output logic [7:0]         reg_rdata_o,
  // raw 10-bit samples from the sensing cell, 64 LSB/g
  input  wire logic [9:0]    acc_x_i,
  input  wire logic [9:0]    acc_y_i,
  input  wire logic [9:0]    acc_z_i,
  // pins
  output logic               sense_enable_o,
  output logic               sample_ready_o,
  output logic               interrupt_out_a_o,
  output logic               interrupt_out_b_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  acl_mode_reg_t mode_q, mode_d;
  logic [7:0]    ctl1_q, ctl1_d, ctl2_q, ctl2_d, thr_q, thr_d;
  logic [7:0]    pdur_q, pdur_d, lat_q, lat_d, tw_q, tw_d;
  logic [1:0]    latclr_q, latclr_d, int_q, int_d;
  logic [2:0]    src_q, src_d;
  logic [9:0]    xv_q, xv_d, yv_q, yv_d, zv_q, zv_d;
  logic          ready_q, ready_d, ovr_q, ovr_d;
  logic [7:0]    rdata_q, rdata_d;
  logic [TMR_W-1:0] samp_cnt_q, samp_cnt_d, det_cnt_q, det_cnt_d;

  logic          running, det_on, samp_fire, det_fire, hit;
  logic          axis_rd, motion, freefall;
  logic [TMR_W-1:0] samp_lim;
  logic [2:0]    en, ge, le;
  logic [9:0]    z_st;
  logic [7:0]    x8, y8, z8;

  ////////////////////////////////////////////////////////////////////////////
  // scaling

  function automatic logic [7:0] sat8(input logic [9:0] v);
    if (v[9:7] == 3'b000 || v[9:7] == 3'b111)
      return v[7:0];
    return v[9] ? 8'h80 : 8'h7F;
  endfunction

  // 8g keeps the top bits, 4g and 2g gain up and saturate
  function automatic logic [7:0] scale8(input logic [9:0] raw,
                                        input acl_range_t r);
    case (r)
      RANGE_2G: return sat8(raw);
      RANGE_4G: return sat8({raw[9], raw[9:1]});
      default:  return raw[9:2];
    endcase
  endfunction

  function automatic logic [9:0] sat10(input logic [10:0] s);
    if (s[10] == s[9])
      return s[9:0];
    return s[10] ? 10'h200 : 10'h1FF;
  endfunction

  // 8-bit view of a held sample: top bits at 8g, scaled value otherwise
  function automatic logic [7:0] view8(input logic [9:0] v,
                                       input acl_range_t r);
    return (r == RANGE_8G) ? v[9:2] : v[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // live values and level compare

  always_comb begin
    z_st = mode_q.selftest_on ?
      sat10({acc_z_i[9], acc_z_i} + SELFTEST_LSB) : acc_z_i;
    x8   = scale8(acc_x_i, mode_q.range_select);
    y8   = scale8(acc_y_i, mode_q.range_select);
    z8   = scale8(z_st, mode_q.range_select);
    en   = ~ctl1_q[CTL1_XDIS +: 3];
  end

  acl_level_cmp u_cmp_x (
    .value_i (x8),
    .thr_i   (thr_q),
    .abs_i   (ctl1_q[CTL1_ABS]),
    .ge_o    (ge[0]),
    .le_o    (le[0])
  );
  acl_level_cmp u_cmp_y (
    .value_i (y8),
    .thr_i   (thr_q),
    .abs_i   (ctl1_q[CTL1_ABS]),
    .ge_o    (ge[1]),
    .le_o    (le[1])
  );
  acl_level_cmp u_cmp_z (
    .value_i (z8),
    .thr_i   (thr_q),
    .abs_i   (ctl1_q[CTL1_ABS]),
    .ge_o    (ge[2]),
    .le_o    (le[2])
  );

  ////////////////////////////////////////////////////////////////////////////
  // timers

  always_comb begin
    running  = mode_q.mode != MODE_STANDBY;
    det_on   = mode_q.mode == MODE_LEVEL ||
               mode_q.mode == MODE_PULSE;
    samp_lim = ctl1_q[CTL1_BW] ? TMR_W'(RATE_HI_CYCLES - 1)
                               : TMR_W'(RATE_LO_CYCLES - 1);
    samp_fire  = running && samp_cnt_q >= samp_lim;
    det_fire   = det_on && det_cnt_q >= TMR_W'(DET_CYCLES - 1);
    samp_cnt_d = (!running || samp_fire) ? '0 : samp_cnt_q + 1'b1;
    det_cnt_d  = (!det_on || det_fire) ? '0 : det_cnt_q + 1'b1;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      samp_cnt_q <= '0;
      det_cnt_q  <= '0;
    end else begin
      samp_cnt_q <= samp_cnt_d;
      det_cnt_q  <= det_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, samples, detection

  always_comb begin
    mode_d   = mode_q;
    ctl1_d   = ctl1_q;
    ctl2_d   = ctl2_q;
    thr_d    = thr_q;
    pdur_d   = pdur_q;
    lat_d    = lat_q;
    tw_d     = tw_q;
    latclr_d = latclr_q;
    xv_d     = xv_q;
    yv_d     = yv_q;
    zv_d     = zv_q;
    rdata_d  = rdata_q;
    ready_d  = ready_q;
    ovr_d    = ovr_q;
    motion   = |(en & ge);
    freefall = (en != 3'b000) && (&(~en | le));
    hit      = det_fire && (ctl2_q[CTL2_POL] ? freefall : motion);
    axis_rd  = reg_req_i.rd && reg_req_i.addr <= ADDR_Z8;

    if (reg_req_i.wr) begin
      if (reg_req_i.addr == ADDR_MODE) begin
        mode_d          = acl_mode_reg_t'(reg_req_i.wdata);
        mode_d.reserved = 1'b0;
      end else if (reg_req_i.addr == ADDR_LATCLR) begin
        latclr_d = reg_req_i.wdata[1:0];
      end else if (reg_req_i.addr == ADDR_CTL1) begin
        ctl1_d = reg_req_i.wdata;
      end else if (reg_req_i.addr == ADDR_CTL2) begin
        ctl2_d = reg_req_i.wdata;
      end else if (reg_req_i.addr == ADDR_THR) begin
        thr_d = reg_req_i.wdata;
      end else if (reg_req_i.addr == ADDR_PDUR) begin
        pdur_d = (reg_req_i.wdata < TMR_MIN) ? TMR_MIN :
                 (reg_req_i.wdata > PDUR_MAX) ? PDUR_MAX :
                 reg_req_i.wdata;
      end else if (reg_req_i.addr == ADDR_LAT) begin
        lat_d = (reg_req_i.wdata < TMR_MIN) ? TMR_MIN :
                (reg_req_i.wdata > LAT_MAX_MS) ? LAT_MAX_MS :
                reg_req_i.wdata;
      end else if (reg_req_i.addr == ADDR_TW) begin
        tw_d = (reg_req_i.wdata > TW_MAX_MS) ? TW_MAX_MS
                                             : reg_req_i.wdata;
      end
    end

    // read side: clears come first so a same-cycle sample still sets
    if (axis_rd)
      ready_d = 1'b0;
    if (reg_req_i.rd && reg_req_i.addr == ADDR_STATUS)
      ovr_d = 1'b0;
    if (samp_fire) begin
      xv_d = (mode_q.range_select == RANGE_8G) ? acc_x_i
                                               : 10'({{2{x8[7]}}, x8});
      yv_d = (mode_q.range_select == RANGE_8G) ? acc_y_i
                                               : 10'({{2{y8[7]}}, y8});
      zv_d = (mode_q.range_select == RANGE_8G) ? z_st
                                               : 10'({{2{z8[7]}}, z8});
      ready_d = 1'b1;
      if (ready_q && !axis_rd)
        ovr_d = 1'b1;
    end

    if (reg_req_i.rd) begin
      if (reg_req_i.addr == ADDR_XL)          rdata_d = xv_q[7:0];
      else if (reg_req_i.addr == ADDR_XH)     rdata_d = {{6{xv_q[9]}}, xv_q[9:8]};
      else if (reg_req_i.addr == ADDR_YL)     rdata_d = yv_q[7:0];
      else if (reg_req_i.addr == ADDR_YH)     rdata_d = {{6{yv_q[9]}}, yv_q[9:8]};
      else if (reg_req_i.addr == ADDR_ZL)     rdata_d = zv_q[7:0];
      else if (reg_req_i.addr == ADDR_ZH)     rdata_d = {{6{zv_q[9]}}, zv_q[9:8]};
      else if (reg_req_i.addr == ADDR_X8)
        rdata_d = view8(xv_q, mode_q.range_select);
      else if (reg_req_i.addr == ADDR_Y8)
        rdata_d = view8(yv_q, mode_q.range_select);
      else if (reg_req_i.addr == ADDR_Z8)
        rdata_d = view8(zv_q, mode_q.range_select);
      else if (reg_req_i.addr == ADDR_STATUS) rdata_d = {6'h00, ovr_q, ready_q};
      else if (reg_req_i.addr == ADDR_DETSRC) rdata_d = {src_q, 3'h0, int_q};
      else if (reg_req_i.addr == ADDR_MODE)   rdata_d = mode_q;
      else if (reg_req_i.addr == ADDR_LATCLR) rdata_d = {6'h00, latclr_q};
      else if (reg_req_i.addr == ADDR_CTL1)   rdata_d = ctl1_q;
      else if (reg_req_i.addr == ADDR_CTL2)   rdata_d = ctl2_q;
      else if (reg_req_i.addr == ADDR_THR)    rdata_d = thr_q;
      else if (reg_req_i.addr == ADDR_PDUR)   rdata_d = pdur_q;
      else if (reg_req_i.addr == ADDR_LAT)    rdata_d = lat_q;
      else if (reg_req_i.addr == ADDR_TW)     rdata_d = tw_q;
      else                                    rdata_d = 8'h00;
    end
  end

  // latched events; a held clear bit blocks setting
  always_comb begin
    int_d = int_q;
    src_d = src_q;
    if (hit && !ctl1_q[CTL1_PIN_SEL] && !latclr_q[0])
      int_d[0] = 1'b1;
    if (hit && ctl1_q[CTL1_PIN_SEL] && !latclr_q[1])
      int_d[1] = 1'b1;
    if (hit && latclr_q == 2'b00)
      src_d = src_q | (en & (ctl2_q[CTL2_POL] ? le : ge));
    if (latclr_q[0])
      int_d[0] = 1'b0;
    if (latclr_q[1])
      int_d[1] = 1'b0;
    if (latclr_q != 2'b00)
      src_d = 3'b000;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q   <= acl_mode_reg_t'(MODE_RST);
      ctl1_q   <= CTL1_RST;
      ctl2_q   <= CTL2_RST;
      thr_q    <= THR_RST;
      pdur_q   <= TMR_RST;
      lat_q    <= TMR_RST;
      tw_q     <= TMR_RST;
      latclr_q <= 2'b00;
      int_q    <= 2'b00;
      src_q    <= 3'b000;
      xv_q     <= 10'h000;
      yv_q     <= 10'h000;
      zv_q     <= 10'h000;
      ready_q  <= 1'b0;
      ovr_q    <= 1'b0;
      rdata_q  <= 8'h00;
    end else begin
      mode_q   <= mode_d;
      ctl1_q   <= ctl1_d;
      ctl2_q   <= ctl2_d;
      thr_q    <= thr_d;
      pdur_q   <= pdur_d;
      lat_q    <= lat_d;
      tw_q     <= tw_d;
      latclr_q <= latclr_d;
      int_q    <= int_d;
      src_q    <= src_d;
      xv_q     <= xv_d;
      yv_q     <= yv_d;
      zv_q     <= zv_d;
      ready_q  <= ready_d;
      ovr_q    <= ovr_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata_o       = rdata_q;
  assign sense_enable_o    = running;
  assign sample_ready_o    = ready_q && !mode_q.ready_pin_suppress;
  assign interrupt_out_a_o = int_q[0];
  assign interrupt_out_b_o = int_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_standby_no_sample: assert property (@(posedge clock_i) disable iff (reset_i)
    mode_q.mode == MODE_STANDBY |=> $stable(xv_q) && $stable(zv_q))
    else $error("sample taken in standby");
  a_ready_after_sample: assert property (@(posedge clock_i) disable iff (reset_i)
    samp_fire |=> ready_q ##0 ($past(ready_q) || !ovr_q || $past(ovr_q)))
    else $error("ready not set after sample");
  a_axis_read_clear: assert property (@(posedge clock_i) disable iff (reset_i)
    axis_rd && !samp_fire |=> !sample_ready_o)
    else $error("ready pin not dropped by axis read");
  a_overrun_set: assert property (@(posedge clock_i) disable iff (reset_i)
    samp_fire && ready_q && !axis_rd |=> ovr_q)
    else $error("overrun missed");
  a_measure_no_event: assert property (@(posedge clock_i) disable iff (reset_i)
    mode_q.mode == MODE_MEASURE |=> !$rose(int_q[0]) && !$rose(int_q[1]))
    else $error("detection in measure mode");
  a_motion_routed_a: assert property (@(posedge clock_i) disable iff (reset_i)
    det_fire && !ctl2_q[CTL2_POL] && |(en & ge) && !ctl1_q[CTL1_PIN_SEL]
    && latclr_q == 2'b00 |=> interrupt_out_a_o && !$rose(int_q[1]))
    else $error("motion not routed to pin a");
  a_freefall_routed_b: assert property (@(posedge clock_i) disable iff (reset_i)
    det_fire && ctl2_q[CTL2_POL] && en == 3'b111 && le == 3'b111
    && ctl1_q[CTL1_PIN_SEL] && latclr_q == 2'b00 |=> interrupt_out_b_o)
    else $error("freefall not routed to pin b");
  a_latch_holds: assert property (@(posedge clock_i) disable iff (reset_i)
    int_q[0] && latclr_q == 2'b00 |=> int_q[0] && src_q >= $past(src_q))
    else $error("latched event lost");
  a_clear_blocks: assert property (@(posedge clock_i) disable iff (reset_i)
    latclr_q[1] |=> !interrupt_out_b_o)
    else $error("pin b set while clear held");
  a_timer_limits: assert property (@(posedge clock_i) disable iff (reset_i)
    lat_q <= LAT_MAX_MS && tw_q <= TW_MAX_MS && pdur_q <= PDUR_MAX)
    else $error("timer register out of range");
  a_selftest_shift: assert property (@(posedge clock_i) disable iff (reset_i)
    samp_fire && mode_q.selftest_on && mode_q.range_select == RANGE_8G
    && acc_z_i == 10'h000 |=> zv_q == 10'h040)
    else $error("self-test shift wrong");

  c_ready:    cover property (@(posedge clock_i) disable iff (reset_i)
    $rose(ready_q));
  c_overrun:  cover property (@(posedge clock_i) disable iff (reset_i)
    $rose(ovr_q));
  c_int_a:    cover property (@(posedge clock_i) disable iff (reset_i)
    $rose(interrupt_out_a_o));
  c_int_b:    cover property (@(posedge clock_i) disable iff (reset_i)
    $rose(interrupt_out_b_o));

endmodule

// File: tb/acl_host_model.sv
`timescale 1ns/1ps
module acl_host_model
  import acl_pkg::*;
(
  // clock
  input  wire logic       clock_i,
  // register port towards the device
  output acl_reg_req_t    reg_req_o,
  input  wire logic [7:0] reg_rdata_i
);

  initial begin
    reg_req_o = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one request per call, launched just after an edge, held one cycle
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    reg_req_o = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    #1;
    // released bus shows inverted values, never the last ones
    reg_req_o = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    #1;
    reg_req_o = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    #1;
    reg_req_o = '{addr: ~a, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
    d = reg_rdata_i;
  endtask

  // both clear bits pulsed, then returned to zero before detection
  task automatic clear_latch();
    write_reg(ADDR_LATCLR, 8'h03);
    write_reg(ADDR_LATCLR, 8'h00);
  endtask

endmodule

// File: tb/acl_ctrl_bench.sv
`timescale 1ns/1ps
module acl_ctrl_bench;
  import acl_pkg::*;

  localparam int unsigned LO  = 40;
  localparam int unsigned HI  = 20;
  localparam int unsigned DET = 16;

  logic         clock_i;
  logic         reset_i;
  acl_reg_req_t reg_req;
  logic [7:0]   rdata;
  logic [9:0]   acc_x;
  logic [9:0]   acc_y;
  logic [9:0]   acc_z;
  logic         sense_en;
  logic         ready_pin;
  logic         int_a;
  logic         int_b;
  int           n_fail;
  int           num_checks;
  logic [7:0]   v;
  int           n;
  logic [7:0]   modes [4] = '{8'h01, 8'h09, 8'h05, 8'h15};
  logic [7:0]   addrs [4] = '{ADDR_YL, ADDR_YL, ADDR_YL, ADDR_ZL};
  logic [7:0]   exps  [4] = '{8'h30, 8'h18, 8'h30, 8'h40};

  acl_ctrl #(
    .RATE_LO_CYCLES (LO),
    .RATE_HI_CYCLES (HI),
    .DET_CYCLES     (DET)
  ) DUT (
    .clock_i           (clock_i),
    .reset_i           (reset_i),
    .reg_req_i         (reg_req),
    .reg_rdata_o       (rdata),
    .acc_x_i           (acc_x),
    .acc_y_i           (acc_y),
    .acc_z_i           (acc_z),
    .sense_enable_o    (sense_en),
    .sample_ready_o    (ready_pin),
    .interrupt_out_a_o (int_a),
    .interrupt_out_b_o (int_b)
  );

  acl_host_model host (
    .clock_i     (clock_i),
    .reg_req_o   (reg_req),
    .reg_rdata_i (rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, checks and ending

  initial begin
    clock_i = 1'b0;
  end

  always begin
    #50 clock_i = ~clock_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (ready_pin !== 1'b1 && cnt < 200) begin
      @(posedge clock_i);
      #1;
      cnt++;
    end
  endtask

  // set up one level case, clear latches, then look at both pins
  task automatic lvl(input logic [7:0] c1, input logic [7:0] c2,
                     input logic [9:0] x, input logic [1:0] exp);
    acc_x = x;
    host.write_reg(ADDR_CTL1, c1);
    host.write_reg(ADDR_CTL2, c2);
    host.clear_latch();
    repeat (40) @(posedge clock_i);
    #1;
    chk({6'h00, int_b, int_a}, {6'h00, exp});
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // tests

  initial begin
    n_fail = 0;
    num_checks = 0;
    reset_i = 1'b1;
    acc_x = 10'h000;
    acc_y = 10'h000;
    acc_z = 10'h000;
    repeat (4) @(posedge clock_i);
    #1;
    reset_i = 1'b0;

    host.read_reg(ADDR_MODE, v);
    chk(v, MODE_RST);
    host.write_reg(ADDR_MODE, 8'hF0);
    host.read_reg(ADDR_MODE, v);
    chk(v, 8'h70);
    host.write_reg(ADDR_MODE, 8'h00);
    host.read_reg(8'h30, v);
    chk(v, 8'h00);
    repeat (100) @(posedge clock_i);
    #1;
    chk({5'h00, sense_en, ready_pin, int_a}, 8'h00);
    host.write_reg(ADDR_PDUR, 8'hFF);
    host.read_reg(ADDR_PDUR, v);
    chk(v, 8'hFE);
    host.write_reg(ADDR_LAT, 8'h00);
    host.read_reg(ADDR_LAT, v);
    chk(v, 8'h01);
    host.write_reg(ADDR_TW, 8'hFF);
    host.read_reg(ADDR_TW, v);
    chk(v, 8'hFA);
    host.write_reg(ADDR_THR, 8'h7F);
    host.read_reg(ADDR_THR, v);
    chk(v, 8'h7F);
    $display("standby test done");

    acc_x = 10'h100;
    acc_y = 10'h030;
    host.write_reg(ADDR_MODE, 8'h01);
    chk({7'h00, sense_en}, 8'h01);
    wait_ready(n);
    host.read_reg(ADDR_STATUS, v);
    chk(v, 8'h01);
    repeat (LO) @(posedge clock_i);
    host.read_reg(ADDR_STATUS, v);
    chk(v, 8'h03);
    host.read_reg(ADDR_XL, v);
    chk(v, 8'h00);
    host.read_reg(ADDR_XH, v);
    chk(v, 8'h01);
    host.read_reg(ADDR_X8, v);
    chk(v, 8'h40);
    chk({7'h00, ready_pin}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.write_reg(ADDR_MODE, modes[i]);
      wait_ready(n);
      host.read_reg(addrs[i], v);
      wait_ready(n);
      host.read_reg(addrs[i], v);
      chk(v, exps[i]);
    end
    $display("measurement test done");

    host.write_reg(ADDR_CTL1, 8'h80);
    host.write_reg(ADDR_MODE, 8'h01);
    wait_ready(n);
    host.read_reg(ADDR_X8, v);
    wait_ready(n);
    host.read_reg(ADDR_X8, v);
    wait_ready(n);
    chk({7'h00, n >= HI - 5 && n <= HI}, 8'h01);
    $display("bandwidth test done");

    acc_y = 10'h000;
    host.write_reg(ADDR_THR, 8'h20);
    lvl(8'h00, 8'h00, 10'h100, 2'b00);
    host.write_reg(ADDR_MODE, 8'h02);
    lvl(8'h00, 8'h00, 10'h100, 2'b01);
    acc_x = 10'h000;
    repeat (40) @(posedge clock_i);
    #1;
    chk({7'h00, int_a}, 8'h01);
    host.read_reg(ADDR_DETSRC, v);
    chk(v & 8'h01, 8'h01);
    host.write_reg(ADDR_LATCLR, 8'h01);
    acc_x = 10'h100;
    repeat (40) @(posedge clock_i);
    #1;
    chk({7'h00, int_a}, 8'h00);
    lvl(8'h01, 8'h00, 10'h100, 2'b10);
    lvl(8'h08, 8'h00, 10'h100, 2'b00);
    lvl(8'h00, 8'h01, 10'h000, 2'b01);
    lvl(8'h00, 8'h01, 10'h100, 2'b00);
    lvl(8'h00, 8'h00, 10'h300, 2'b00);
    lvl(8'h40, 8'h00, 10'h300, 2'b01);
    $display("level test done");
    complete_run();
  end

endmodule
